//--- iseq_pkg.sv
// package: register map, field positions and types for the input select / equalizer control bank
package iseq_pkg;
   // register offsets
   localparam logic [7:0] ISEQ_OFF_MANUAL_EQ = 8'h04;
   localparam logic [7:0] ISEQ_OFF_CC_TUNE1 = 8'h46;
   localparam logic [7:0] ISEQ_OFF_FWD_TUNE1 = 8'h47;
   localparam logic [7:0] ISEQ_OFF_CHAN_SEL = 8'h4c;
   localparam logic [7:0] ISEQ_OFF_EQ_TEST = 8'h4d;
   localparam logic [7:0] ISEQ_OFF_EQ_LEVEL = 8'h4e;
   // reset values
   localparam logic [7:0] ISEQ_RST_ZERO = 8'h00;
   localparam logic [7:0] ISEQ_RST_EQ_TEST = 8'h20;
   // field positions
   localparam int ISEQ_TERM_LSB = 2;
   localparam int ISEQ_SEL_OVR_BIT = 7;
   localparam int ISEQ_SEL_CHAN_BIT = 6;
   localparam int ISEQ_BYPASS_BIT = 6;
   localparam int ISEQ_LEVEL_LSB = 4;
   localparam int ISEQ_MAN_LEVEL_LSB = 4;
   // adaptation timing: top count of the step counter between level steps
   localparam logic [7:0] ISEQ_STEP_CYCLES = 8'h40;
   // thermometer levels
   localparam logic [3:0] ISEQ_LEVEL_MIN = 4'h0;
   localparam logic [3:0] ISEQ_LEVEL_MAX = 4'hf;

   // register-port request carrier
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } iseq_req_s;

   // adaptation state
   typedef enum logic [1:0] {
      ISEQ_ST_RESET = 2'b00,
      ISEQ_ST_SEARCH = 2'b01,
      ISEQ_ST_LOCKED = 2'b10
   } iseq_state_e;
endpackage : iseq_pkg

//--- iseq_sync2.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
module iseq_sync2
   import iseq_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // async level in, synced level out
   input wire logic async_in,
   output logic sync_out
);
   // both stages in one struct; only stage two is read outside
   typedef struct packed {
      logic s1;
      logic s2;
   } iseq_sync_s;
   iseq_sync_s st_q;
   iseq_sync_s st_d;

   // shift the pin through two stages
   always_comb begin
      st_d = st_q;
      st_d.s1 = async_in;
      st_d.s2 = st_q.s1;
   end

   // register, cleared on reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_out = st_q.s2;
endmodule : iseq_sync2

//--- iseq_ctrl.sv
// input select and equalizer control register bank
`timescale 1ns/1ns
// Summary of operation
// - termination code picks 50/47.4/45.3/37.7 ohm
// - override bit chooses pin or register select
// - register select 0 routes input 0
// - bypass bit applies manual level, stops adaptation
// - readback shows thermometer level, resets 0000
// - lock loss in the locked state resets equalizer, restarts acquisition
//
// the bank is reached as single bytes through a strobe port on sys_clk:
// a write lands on the next edge, a read answers one clock later
// pins and receiver status arrive asynchronously and pass two flops
// each before any logic reads them, so a select pin change shows at
// the selected-input output two clocks after it is first sampled
// the adaptive search steps one thermometer level per interval and
// wraps from maximum back to minimum; slower than a binary search,
// but it never jumps past a level the far end could lock at
// bypass holds the sequencer in its restart state, so clearing the
// bypass bit always begins a fresh search from the minimum level
// power down acts as a register reset held every clock, so writes
// made while the pin is low are lost
// reserved bits are stored as written; keeping them intact is left
// to software, which keeps the logic free of per-bit masks
//
module iseq_ctrl
   import iseq_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register port, same clock domain
   input wire iseq_req_s reg_req,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // pins
   input wire logic input_select_pin,
   input wire logic powerdown_pin_active_low,
   // link status from the receiver
   input wire logic link_lock,
   input wire logic eq_quality_ok,
   // analogue controls
   output logic [1:0] back_control_channel_term,
   output logic [7:0] forward_channel_impedance,
   output logic active_input,
   output logic serial_input_one_en,
   output logic [3:0] eq_level,
   output logic adaptive_equalizer_active
);
   // all state in one struct
   // one register for every flop of the bank keeps reset and update
   // in a single place; the next value is built as a whole copy
   // and only the fields a branch touches differ from the current one
   typedef struct packed {
      logic [7:0] manual_eq;
      logic [7:0] cc_tune1;
      logic [7:0] fwd_tune1;
      logic [7:0] chan_sel;
      logic [7:0] eq_test;
      logic [3:0] level;
      iseq_state_e state;
      logic [7:0] step_cnt;
      logic active;
      logic [7:0] rdata;
      logic rvalid;
   } iseq_state_s;
   iseq_state_s st_q;
   iseq_state_s st_d;

   logic sel_pin_s; // synced select pin
   // the pin is inverted before syncing so the flops' cleared state
   // means powered up; otherwise the first clocks after rst would
   // look like power down and swallow the earliest writes
   logic pd_req; // power-down request, high while the pin is low
   logic pd_s; // synced power-down request
   logic lock_s; // synced lock status
   logic ok_s; // synced quality flag
   logic bypass; // manual equalization chosen
   logic [3:0] man_level; // manual level field

   // pins cross into sys_clk through two flops each
   iseq_sync2 u_sync_sel (.sys_clk(sys_clk), .rst(rst), .async_in(input_select_pin), .sync_out(sel_pin_s));
   // power down crosses as an active-high request
   assign pd_req = ~powerdown_pin_active_low;
   iseq_sync2 u_sync_pdb (.sys_clk(sys_clk), .rst(rst), .async_in(pd_req), .sync_out(pd_s));
   iseq_sync2 u_sync_lock (.sys_clk(sys_clk), .rst(rst), .async_in(link_lock), .sync_out(lock_s));
   iseq_sync2 u_sync_ok (.sys_clk(sys_clk), .rst(rst), .async_in(eq_quality_ok), .sync_out(ok_s));

   assign bypass = st_q.eq_test[ISEQ_BYPASS_BIT];
   // manual level comes from the upper nibble of the manual register
   assign man_level = st_q.manual_eq[ISEQ_MAN_LEVEL_LSB +: 4];

   // next-state logic: register writes, reads, adaptation
   always_comb begin
      st_d = st_q;
      st_d.rvalid = 1'b0;
      // writes store all bits; reserved bits kept by software
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            ISEQ_OFF_MANUAL_EQ: st_d.manual_eq = reg_req.wdata;
            ISEQ_OFF_CC_TUNE1: st_d.cc_tune1 = reg_req.wdata;
            // forward impedance, value chosen by software
            ISEQ_OFF_FWD_TUNE1: st_d.fwd_tune1 = reg_req.wdata;
            ISEQ_OFF_CHAN_SEL: st_d.chan_sel = reg_req.wdata;
            ISEQ_OFF_EQ_TEST: st_d.eq_test = reg_req.wdata;
            // readback and unmapped: write ignored
            default: st_d.chan_sel = st_q.chan_sel;
         endcase
      end
      // read data registered, one cycle after the request
      if (reg_req.rd) begin
         st_d.rvalid = 1'b1;
         // reads use the current flops, so a write to the same offset
         // in the same clock is not yet visible
         unique case (reg_req.addr)
            // stored bytes read back as written, reserved bits included
            ISEQ_OFF_MANUAL_EQ: st_d.rdata = st_q.manual_eq;
            ISEQ_OFF_CC_TUNE1: st_d.rdata = st_q.cc_tune1;
            ISEQ_OFF_FWD_TUNE1: st_d.rdata = st_q.fwd_tune1;
            ISEQ_OFF_CHAN_SEL: st_d.rdata = st_q.chan_sel;
            ISEQ_OFF_EQ_TEST: st_d.rdata = st_q.eq_test;
            // level readback, low nibble reads zero
            ISEQ_OFF_EQ_LEVEL: st_d.rdata = {st_q.level, 4'h0};
            // unmapped offsets read as zero
            default: st_d.rdata = ISEQ_RST_ZERO;
         endcase
      end
      // pin or register decides the input
      if (st_q.chan_sel[ISEQ_SEL_OVR_BIT]) begin
         // register bit routes channel 0 or 1
         st_d.active = st_q.chan_sel[ISEQ_SEL_CHAN_BIT];
      end else begin
         st_d.active = sel_pin_s;
      end
      // equalizer sequencing
      // power down wins over bypass and adaptation
      if (pd_s) begin
         // held in power down: level back to minimum
         st_d.state = ISEQ_ST_RESET;
         st_d.level = ISEQ_LEVEL_MIN;
         st_d.step_cnt = '0;
      end else if (bypass) begin
         st_d.level = man_level;
         st_d.state = ISEQ_ST_RESET;
         st_d.step_cnt = '0;
      end else begin
         unique case (st_q.state)
            ISEQ_ST_RESET: begin
               // restart from the minimum boost
               st_d.level = ISEQ_LEVEL_MIN;
               st_d.step_cnt = '0;
               st_d.state = ISEQ_ST_SEARCH;
            end
            ISEQ_ST_SEARCH: begin
               // step one thermometer level each interval until locked and clean
               // a step lands one clock after the counter reaches its top,
               // so an interval is one clock longer than the top count
               if (lock_s && ok_s) begin
                  st_d.state = ISEQ_ST_LOCKED;
               end else if (st_q.step_cnt == ISEQ_STEP_CYCLES) begin
                  st_d.step_cnt = '0;
                  // wrap to minimum after maximum: keep sweeping
                  st_d.level = (st_q.level == ISEQ_LEVEL_MAX) ? ISEQ_LEVEL_MIN : {st_q.level[2:0], 1'b1};
               end else begin
                  st_d.step_cnt = st_q.step_cnt + 8'h01;
               end
            end
            ISEQ_ST_LOCKED: begin
               // level frozen while locked: no retuning on a live link
               // lock loss restarts the equalizer
               if (!lock_s) begin
                  st_d.state = ISEQ_ST_RESET;
               end
            end
            // unused code recovers to reset
            default: st_d.state = ISEQ_ST_RESET;
         endcase
      end
      // a powered-down device loses its register contents
      // reset values restored every clock the request is held
      if (pd_s) begin
         st_d.manual_eq = ISEQ_RST_ZERO;
         st_d.cc_tune1 = ISEQ_RST_ZERO;
         st_d.fwd_tune1 = ISEQ_RST_ZERO;
         st_d.chan_sel = ISEQ_RST_ZERO;
         st_d.eq_test = ISEQ_RST_EQ_TEST;
      end
   end

   // state register; synchronous reset to the register map's reset values
   // fields start at zero, then the test-mode register and the
   // sequencer state are given their own reset values
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;
         st_q.eq_test <= ISEQ_RST_EQ_TEST;
         st_q.state <= ISEQ_ST_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // termination code to the analogue trim
   assign back_control_channel_term = st_q.cc_tune1[ISEQ_TERM_LSB +: 2];
   assign forward_channel_impedance = st_q.fwd_tune1;
   // selected input and its enable share one flop
   // so the two can never disagree
   assign active_input = st_q.active;
   assign serial_input_one_en = st_q.active;
   // level straight from the state flop
   assign eq_level = st_q.level;
   assign adaptive_equalizer_active = ~bypass;
   // read port: data holds until the next read, valid pulses
   // for a single clock
   assign reg_rdata = st_q.rdata;
   assign reg_rvalid = st_q.rvalid;
endmodule : iseq_ctrl

//--- iseq_ctrl_chk.sv
// checker for the input select and equalizer bank
`timescale 1ns/1ns
module iseq_ctrl_chk
   import iseq_pkg::*;
(
   // clock, reset, register port
   input wire logic sys_clk,
   input wire logic rst,
   input wire iseq_req_s reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   // pins, link, controls
   input wire logic input_select_pin,
   input wire logic powerdown_pin_active_low,
   input wire logic link_lock,
   input wire logic [1:0] back_control_channel_term,
   input wire logic active_input,
   input wire logic [3:0] eq_level,
   input wire logic adaptive_equalizer_active
);
   // shadows of override, bypass, manual level
   logic ovr_q, byp_q;
   logic [3:0] man_q;
   wire logic w = reg_req.wr;
   wire logic [7:0] a = reg_req.addr;
   wire logic [7:0] d = reg_req.wdata;
   always_ff @(posedge sys_clk) begin
      if (rst || !powerdown_pin_active_low) begin
         {ovr_q, byp_q, man_q} <= '0;
      end else if (w) begin
         if (a == ISEQ_OFF_CHAN_SEL) ovr_q <= d[ISEQ_SEL_OVR_BIT];
         if (a == ISEQ_OFF_EQ_TEST) byp_q <= d[ISEQ_BYPASS_BIT];
         if (a == ISEQ_OFF_MANUAL_EQ) man_q <= d[ISEQ_MAN_LEVEL_LSB +: 4];
      end
   end
   // power-down acts as reset, so it disables too
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst || !powerdown_pin_active_low);
   AST_TERM: assert property (w && a == ISEQ_OFF_CC_TUNE1 |=> back_control_channel_term == $past(d[3:2]))
      else $error("termination code wrong");
   AST_SELR: assert property (w && a == ISEQ_OFF_CHAN_SEL && d[7] ##1 !(w && a == ISEQ_OFF_CHAN_SEL)
      |=> active_input == $past(d[6], 2)) else $error("register select ignored");
   AST_PIN: assert property ((!ovr_q && $stable(input_select_pin))[*5] |-> active_input == input_select_pin)
      else $error("pin select ignored");
   AST_BYP: assert property (adaptive_equalizer_active != byp_q)
      else $error("bypass state wrong");
   AST_MAN: assert property (byp_q && $past(byp_q) |-> eq_level == $past(man_q))
      else $error("manual level wrong");
   AST_THERM: assert property (eq_level inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
      else $error("level not thermometer");
   AST_RDLV: assert property (reg_req.rd && a == ISEQ_OFF_EQ_LEVEL |=> reg_rvalid && reg_rdata == {$past(eq_level), 4'h0})
      else $error("level readback wrong");
   AST_LOSS: assert property ($fell(link_lock) && !byp_q ##1 (!link_lock && !byp_q)[*4] |=> eq_level == 4'h0)
      else $error("lock loss kept level");
   // main scenarios
   cover property (w && a == ISEQ_OFF_CHAN_SEL && d[7]);
   cover property (byp_q && eq_level == 4'hf);
   cover property ($fell(link_lock));
endmodule : iseq_ctrl_chk
bind iseq_ctrl iseq_ctrl_chk u_chk (.sys_clk, .rst, .reg_req, .reg_rdata, .reg_rvalid, .input_select_pin,
   .powerdown_pin_active_low, .link_lock, .back_control_channel_term, .active_input, .eq_level,
   .adaptive_equalizer_active);

//--- iseq_partner.sv
// remote serializer model: locked while cabled, good at one level
`timescale 1ns/1ns
module iseq_partner
   import iseq_pkg::*;
#(
   parameter logic [3:0] GOOD_LEVEL = 4'h3
)
(
   // clock, cable, receiver level
   input wire logic sys_clk,
   input wire logic cable_on,
   input wire logic [3:0] eq_level,
   // link status toward the receiver
   output logic link_lock,
   output logic eq_quality_ok
);
   // lock follows the cable at once; quality is judged a clock late,
   // as a receiver would, and only at one level so adaptation must search
   assign link_lock = cable_on;
   always_ff @(posedge sys_clk) begin
      eq_quality_ok <= cable_on && (eq_level === GOOD_LEVEL);
   end
endmodule : iseq_partner

//--- iseq_ctrl_tb_top.sv
// testbench for the input select and equalizer bank
`timescale 1ns/1ns
module iseq_ctrl_tb_top
   import iseq_pkg::*;
;
   logic sys_clk = 1'b0, rst = 1'b1, pin = 1'b0, powerdown_pin_active_low = 1'b1, cable = 1'b0;
   iseq_req_s req = '0;
   logic [7:0] rdata, fwd;
   logic rvalid, act, one_en, aeq_on, lock, ok;
   logic [1:0] term;
   logic [3:0] lvl;
   int fail_count = 0, num_checks = 0, cyc = 0;
   iseq_ctrl dut (.sys_clk, .rst, .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid), .input_select_pin(pin),
      .powerdown_pin_active_low, .link_lock(lock), .eq_quality_ok(ok), .back_control_channel_term(term),
      .forward_channel_impedance(fwd), .active_input(act), .serial_input_one_en(one_en), .eq_level(lvl),
      .adaptive_equalizer_active(aeq_on));
   iseq_partner far (.sys_clk, .cable_on(cable), .eq_level(lvl), .link_lock(lock), .eq_quality_ok(ok));
   initial forever #4 sys_clk = ~sys_clk;
   // hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : settle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk) req <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk) req <= '0;
   endtask : wr
   // answer is one cycle after the read edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk) req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk) req <= '0;
      @(negedge sys_clk);
      chk({7'h00, rvalid}, 8'h01);
      chk(rdata, exp);
      // valid is a single-clock pulse
      @(negedge sys_clk);
      chk({7'h00, rvalid}, 8'h00);
   endtask : rd
   task automatic t_term();
      for (int c = 0; c < 4; c++) begin
         wr(ISEQ_OFF_CC_TUNE1, 8'(c << 2));
         settle(1);
         chk({6'h00, term}, 8'(c));
      end
      rd(ISEQ_OFF_CC_TUNE1, 8'h0c);
      wr(ISEQ_OFF_FWD_TUNE1, 8'h70);
      settle(1);
      chk(fwd, 8'h70);
      rd(ISEQ_OFF_FWD_TUNE1, 8'h70);
      wr(ISEQ_OFF_FWD_TUNE1, 8'h00);
   endtask : t_term
   task automatic t_sel();
      @(posedge sys_clk) pin <= 1'b1;
      settle(3);
      chk({7'h00, act}, 8'h01);
      wr(ISEQ_OFF_CHAN_SEL, 8'h80);
      settle(1);
      chk({7'h00, act}, 8'h00);
      wr(ISEQ_OFF_CHAN_SEL, 8'hc0);
      @(posedge sys_clk) pin <= 1'b0;
      settle(3);
      chk({6'h00, act, one_en}, 8'h03);
      wr(ISEQ_OFF_CHAN_SEL, 8'h00);
      settle(1);
      chk({7'h00, act}, 8'h00);
   endtask : t_sel
   task automatic t_eq();
      @(posedge sys_clk) cable <= 1'b1;
      settle(400);
      chk({4'h0, lvl}, 8'h03);
      rd(ISEQ_OFF_EQ_LEVEL, 8'h30);
      @(posedge sys_clk) cable <= 1'b0;
      settle(6);
      chk({4'h0, lvl}, 8'h00);
      settle(70);
      chk({4'h0, lvl}, 8'h01);
      wr(ISEQ_OFF_MANUAL_EQ, 8'hf0);
      wr(ISEQ_OFF_EQ_TEST, 8'h60);
      settle(2);
      chk({3'h0, aeq_on, lvl}, 8'h0f);
      wr(ISEQ_OFF_EQ_LEVEL, 8'h55);
      rd(ISEQ_OFF_EQ_LEVEL, 8'hf0);
      wr(ISEQ_OFF_MANUAL_EQ, 8'h70);
      settle(2);
      chk({4'h0, lvl}, 8'h07);
      rd(ISEQ_OFF_MANUAL_EQ, 8'h70);
      wr(ISEQ_OFF_EQ_TEST, 8'h20);
      settle(1);
      chk({7'h00, aeq_on}, 8'h01);
   endtask : t_eq
   task automatic t_pd();
      wr(ISEQ_OFF_CHAN_SEL, 8'hc0);
      @(posedge sys_clk) powerdown_pin_active_low <= 1'b0;
      settle(4);
      @(posedge sys_clk) powerdown_pin_active_low <= 1'b1;
      settle(3);
      rd(ISEQ_OFF_CHAN_SEL, 8'h00);
   endtask : t_pd
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      // first request right at the first edge after release
      wr(ISEQ_OFF_CC_TUNE1, 8'h04);
      rd(ISEQ_OFF_EQ_LEVEL, 8'h00);
      rd(ISEQ_OFF_EQ_TEST, 8'h20);
      rd(ISEQ_OFF_CHAN_SEL, 8'h00);
      rd(8'h48, 8'h00);
      rd(ISEQ_OFF_CC_TUNE1, 8'h04);
      t_term();
      t_sel();
      t_eq();
      t_pd();
      close_out();
   end
endmodule : iseq_ctrl_tb_top
